// [core/cold_redundancy_controller.sv]
// Purpose: Cold redundancy role register, wake/fault line and standby gating
// Assumes: One 25 MHz clock; share level code is made on the same clock
// Notes:   Role register reached over SMBus byte read/write; PEC needed on writes, optional on reads
`timescale 1ns/100ps
module cold_redundancy_controller
(
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST_N,
  // SMBus pins (open drain data)
  input  wire logic                        SMB_SCL_I,
  input  wire logic                        SMB_SDA_I,
  output logic                             SMB_SDA_O,
  output logic                             SMB_SDA_OE_N,
  // Shared wake/fault line
  input  wire logic                        WAKE_FAULT_I,
  output logic                             WAKE_FAULT_O,
  output logic                             WAKE_FAULT_OE_N,
  // Supply pins and internal status
  input  wire logic                        SUPPLY_ON_REQUEST_N,
  input  wire logic                        REDUNDANCY_ENABLE_N,
  input  wire logic                        INTERNAL_FAULT,
  input  wire logic                        VOUT_UNDER_FAULT,
  input  wire logic                        CONV_POWER_GOOD,
  input  wire logic [cr_pkg::SHARE_W-1:0]  SHARE_LEVEL,
  // Power stage controls
  output logic                             MAIN_ON,
  output logic                             POWER_GOOD,
  output logic                             FANS_ON,
  output logic                             DUMMY_LOAD_ON,
  output logic                             SOFT_START_EN,
  output logic                             STATUS_REPORT_EN,
  output logic [7:0]                       ROLE
);
  import cr_pkg::*;

  logic [SYN_W-1:0]   syn1_r;
  logic [SYN_W-1:0]   syn2_r;
  logic               scl_d_r;
  logic               sda_d_r;
  logic               pg_s1_r;
  logic               pg_s2_r;
  bus_state_t         bus_r;
  logic [3:0]         bit_cnt_r;
  logic [7:0]         shift_r;
  logic [7:0]         tx_sh_r;
  logic [7:0]         crc_r;
  logic [7:0]         crc_nxt;
  logic [7:0]         wdata_r;
  logic               cmd_ok_r;
  logic               wr_stb_r;
  logic [7:0]         role_r;
  logic [2:0]         drv_hist_r;
  ctrl_state_t        ctrl_r;
  ctrl_state_t        ctrl_nxt;
  logic               scl_rise;
  logic               scl_fall;
  logic               bus_start;
  logic               bus_stop;
  logic               fault_now;
  logic               ext_low;
  logic               stby_cond;

  // Role decode, shared by several places
  function automatic logic is_standby(input logic [7:0] r);
    return (r == ROLE_STBY1) || (r == ROLE_STBY2) || (r == ROLE_STBY3);
  endfunction

  function automatic logic role_valid(input logic [7:0] r);
    return (r == ROLE_STANDARD) || (r == ROLE_ACTIVE) || is_standby(r);
  endfunction

  // Wake and sleep thresholds per position
  function automatic logic [11:0] wake_share_level(input logic [7:0] r);
    case (r)
      ROLE_STBY1: return WAKE_LVL1;
      ROLE_STBY2: return WAKE_LVL2;
      default:    return WAKE_LVL3;
    endcase
  endfunction

  function automatic logic [11:0] sleep_share_level(input logic [7:0] r);
    case (r)
      ROLE_STBY1: return SLEEP_LVL1;
      ROLE_STBY2: return SLEEP_LVL2;
      default:    return SLEEP_LVL3;
    endcase
  endfunction

  // Two-flop synchronisers for every pin from outside the clock domain
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      syn1_r  <= SYN_IDLE;
      syn2_r  <= SYN_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
    end
    else
    begin
      syn1_r  <= {VOUT_UNDER_FAULT, INTERNAL_FAULT, REDUNDANCY_ENABLE_N,
                  SUPPLY_ON_REQUEST_N, WAKE_FAULT_I, SMB_SDA_I, SMB_SCL_I};
      syn2_r  <= syn1_r;
      scl_d_r <= syn2_r[SY_SCL];
      sda_d_r <= syn2_r[SY_SDA];
      pg_s1_r <= CONV_POWER_GOOD;
      pg_s2_r <= pg_s1_r;
    end
  end

  // Bus conditions, seen only after synchronisation
  assign scl_rise  = syn2_r[SY_SCL] & ~scl_d_r;
  assign scl_fall  = ~syn2_r[SY_SCL] & scl_d_r;
  assign bus_start = syn2_r[SY_SCL] & scl_d_r & sda_d_r & ~syn2_r[SY_SDA];
  assign bus_stop  = syn2_r[SY_SCL] & scl_d_r & ~sda_d_r & syn2_r[SY_SDA];

  pec_crc8_step u_pec
  (
    .crc_in  (crc_r),
    .data_in (shift_r),
    .crc_out (crc_nxt)
  );

  // SMBus byte engine: only the role command is acknowledged
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      bus_r        <= BS_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      tx_sh_r      <= 8'h00;
      crc_r        <= PEC_INIT;
      wdata_r      <= 8'h00;
      cmd_ok_r     <= 1'b0;
      wr_stb_r     <= 1'b0;
      SMB_SDA_OE_N <= 1'b1;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      if (bus_start)
      begin
        bus_r        <= BS_ADDR;
        bit_cnt_r    <= 4'h0;
        SMB_SDA_OE_N <= 1'b1;
        // A repeated start after the command keeps the running code
        if (bus_r != BS_WDATA)
          crc_r <= PEC_INIT;
      end
      else if (bus_stop)
      begin
        bus_r        <= BS_IDLE;
        cmd_ok_r     <= 1'b0;
        SMB_SDA_OE_N <= 1'b1;
      end
      else
      begin
        if (scl_rise)
        begin
          if (bit_cnt_r == BIT_ACK)
          begin
            bit_cnt_r <= 4'h0;
            // Master ack after our data byte asks for the PEC byte;
            // our own address ack still pulls SDA, so it is not taken
            if (bus_r == BS_RDATA && SMB_SDA_OE_N && !syn2_r[SY_SDA])
            begin
              bus_r   <= BS_RPEC;
              tx_sh_r <= crc_r;
            end
            else if (SMB_SDA_OE_N && (bus_r == BS_RDATA || bus_r == BS_RPEC))
              bus_r <= BS_IDLE;
          end
          else
          begin
            shift_r   <= {shift_r[6:0], syn2_r[SY_SDA]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        if (scl_fall)
        begin
          if (bit_cnt_r == BIT_ACK)
          begin
            SMB_SDA_OE_N <= 1'b1;
            if (bus_r != BS_WPEC && bus_r != BS_RPEC)
              crc_r <= crc_nxt;
            case (bus_r)
              BS_ADDR:
              begin
                if (shift_r[7:1] != DEV_ADDR)
                  bus_r <= BS_IDLE;
                else if (!shift_r[0])
                begin
                  SMB_SDA_OE_N <= 1'b0;
                  bus_r        <= BS_CMD;
                end
                else if (cmd_ok_r)
                begin
                  SMB_SDA_OE_N <= 1'b0;
                  bus_r        <= BS_RDATA;
                  tx_sh_r      <= role_r;
                end
                else
                  bus_r <= BS_IDLE;
              end
              BS_CMD:
              begin
                if (shift_r == CMD_ROLE_CFG)
                begin
                  SMB_SDA_OE_N <= 1'b0;
                  cmd_ok_r     <= 1'b1;
                  bus_r        <= BS_WDATA;
                end
                else
                  bus_r <= BS_IDLE;
              end
              BS_WDATA:
              begin
                SMB_SDA_OE_N <= 1'b0;
                wdata_r      <= shift_r;
                bus_r        <= BS_WPEC;
              end
              BS_WPEC:
              begin
                // Bad PEC or unknown role is refused with a NACK
                if (shift_r == crc_r && role_valid(wdata_r))
                begin
                  SMB_SDA_OE_N <= 1'b0;
                  wr_stb_r     <= 1'b1;
                end
                bus_r <= BS_IDLE;
              end
              default:
              begin
              end
            endcase
          end
          else if (bus_r == BS_RDATA || bus_r == BS_RPEC)
          begin
            SMB_SDA_OE_N <= tx_sh_r[7];
            tx_sh_r      <= {tx_sh_r[6:0], 1'b0};
          end
          else
            SMB_SDA_OE_N <= 1'b1;
        end
      end
    end
  end

  // Data side of the open-drain pin never drives high
  always_ff @(posedge CLK_SYS)
  begin
    SMB_SDA_O <= 1'b0;
  end

  // A low line while we have not pulled it in the last cycles is external
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      drv_hist_r <= DRV_HIST_RST;
    else
      drv_hist_r <= {drv_hist_r[1:0], ~WAKE_FAULT_OE_N & ~WAKE_FAULT_O};
  end

  assign ext_low   = ~syn2_r[SY_WAKE] & ~(|drv_hist_r);
  assign fault_now = syn2_r[SY_FAULT] | (syn2_r[SY_VLOW] & MAIN_ON);
  assign stby_cond = ~syn2_r[SY_ONREQ_N] & syn2_r[SY_REDEN_N]
                     & is_standby(role_r);

  // Role register; the hardware rewrite wins over a bus write
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      role_r <= ROLE_STANDARD;
    else if (is_standby(role_r) && ext_low)
      role_r <= ROLE_STANDARD;
    else if (wr_stb_r)
      role_r <= wdata_r;
  end

  // Supply state: standby moves on the share comparison; sleep also wakes on an external low on the wake line
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (syn2_r[SY_ONREQ_N])
      ctrl_nxt = CS_OFF;
    else if (!stby_cond)
      ctrl_nxt = CS_ON;
    else
    begin
      case (ctrl_r)
        CS_SLEEP:
          if (SHARE_LEVEL >= wake_share_level(role_r) || ext_low)
            ctrl_nxt = CS_AWAKE;
        CS_AWAKE:
          if (SHARE_LEVEL < sleep_share_level(role_r))
            ctrl_nxt = CS_SLEEP;
        default:
          ctrl_nxt = CS_SLEEP;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      ctrl_r <= CS_OFF;
    else
      ctrl_r <= ctrl_nxt;
  end

  // Power stage controls, registered from the next state
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      MAIN_ON          <= 1'b0;
      POWER_GOOD       <= 1'b0;
      FANS_ON          <= 1'b0;
      DUMMY_LOAD_ON    <= 1'b0;
      SOFT_START_EN    <= 1'b1;
      STATUS_REPORT_EN <= 1'b0;
    end
    else
    begin
      MAIN_ON          <= ctrl_nxt == CS_ON || ctrl_nxt == CS_AWAKE;
      // Output caps stay charged, so the system sees a good rail
      POWER_GOOD       <= ctrl_nxt == CS_SLEEP || (pg_s2_r && ctrl_nxt != CS_OFF);
      FANS_ON          <= ctrl_nxt == CS_ON || ctrl_nxt == CS_AWAKE;
      DUMMY_LOAD_ON    <= ctrl_nxt == CS_ON || ctrl_nxt == CS_AWAKE;
      // No slow ramp on wake, so the standby supply catches the load
      SOFT_START_EN    <= ctrl_nxt == CS_ON || ctrl_nxt == CS_OFF;
      STATUS_REPORT_EN <= ctrl_nxt == CS_ON;
    end
  end

  // Wake/fault line: low on fault, high for active role while supply is on, else released
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      WAKE_FAULT_O    <= 1'b0;
      WAKE_FAULT_OE_N <= 1'b1;
    end
    else if (fault_now)
    begin
      WAKE_FAULT_O    <= 1'b0;
      WAKE_FAULT_OE_N <= 1'b0;
    end
    else if (role_r == ROLE_ACTIVE && ctrl_nxt == CS_ON)
    begin
      WAKE_FAULT_O    <= 1'b1;
      WAKE_FAULT_OE_N <= 1'b0;
    end
    else
    begin
      WAKE_FAULT_O    <= 1'b0;
      WAKE_FAULT_OE_N <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      ROLE <= ROLE_STANDARD;
    else
      ROLE <= role_r;
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_sleeping;
    ctrl_r == CS_SLEEP;
  endsequence
  sequence s_awake_cross;
    ctrl_r == CS_SLEEP && stby_cond && SHARE_LEVEL >= wake_share_level(role_r);
  endsequence

  property p_sleep_outputs;
    s_sleeping |=> POWER_GOOD && !FANS_ON && !DUMMY_LOAD_ON && !MAIN_ON
                   || ctrl_r != CS_SLEEP;
  endproperty
  a_sleep_outputs: assert property (p_sleep_outputs)
    else $error("sleep outputs wrong");
  property p_standby_softstart;
    (ctrl_r == CS_SLEEP || ctrl_r == CS_AWAKE) |-> !SOFT_START_EN && !STATUS_REPORT_EN;
  endproperty
  a_standby_softstart: assert property (p_standby_softstart)
    else $error("soft start or status on in standby");
  property p_line_states;
    WAKE_FAULT_OE_N |-> !WAKE_FAULT_O;
  endproperty
  a_line_states: assert property (p_line_states)
    else $error("released line carries a high");
  property p_fault_low;
    syn2_r[SY_FAULT] |=> !WAKE_FAULT_OE_N && !WAKE_FAULT_O;
  endproperty
  a_fault_low: assert property (p_fault_low)
    else $error("fault did not pull the line low");
  property p_active_high;
    role_r == ROLE_ACTIVE && !fault_now && ctrl_nxt == CS_ON |=> WAKE_FAULT_O;
  endproperty
  a_active_high: assert property (p_active_high)
    else $error("active role not driving high");
  property p_rewrite;
    is_standby(role_r) && ext_low |=> role_r == ROLE_STANDARD ##1 ctrl_r == CS_ON
                                      || syn2_r[SY_ONREQ_N];
  endproperty
  a_rewrite: assert property (p_rewrite)
    else $error("standby role not rewritten on wake line low");
  property p_wake;
    s_awake_cross |=> ctrl_r == CS_AWAKE ##1 MAIN_ON || ctrl_r != CS_AWAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake at enable threshold");
  property p_sleep_back;
    ctrl_r == CS_AWAKE && stby_cond && SHARE_LEVEL < sleep_share_level(role_r)
      |=> ctrl_r == CS_SLEEP;
  endproperty
  a_sleep_back: assert property (p_sleep_back)
    else $error("no return to sleep below disable threshold");
  property p_standby_entry;
    ctrl_r == CS_SLEEP |-> $past(stby_cond) && is_standby($past(role_r));
  endproperty
  a_standby_entry: assert property (p_standby_entry)
    else $error("standby without its conditions");
  property p_write_pec;
    wr_stb_r |-> $past(shift_r) == $past(crc_r) && role_valid(wdata_r);
  endproperty
  a_write_pec: assert property (p_write_pec)
    else $error("role written without good PEC");

endmodule // cold_redundancy_controller

// [core/cr_pkg.sv]
// Purpose: Shared constants and types for the cold redundancy controller
// Assumes: Share level arrives as a 12-bit code in 10 mV steps (800 = 8.0 V)
// Notes:   Thresholds are per-model tuning points; edit here only
package cr_pkg;

  // SMBus addressing and command
  localparam logic [6:0]  DEV_ADDR      = 7'h58;  // Arbitrary default slave address
  localparam logic [7:0]  CMD_ROLE_CFG  = 8'hd0;
  localparam logic [7:0]  PEC_POLY      = 8'h07;
  localparam logic [7:0]  PEC_INIT      = 8'h00;
  localparam logic [3:0]  BIT_ACK       = 4'h8;   // Bit count at the ack slot

  // Role register values
  localparam logic [7:0]  ROLE_STANDARD = 8'h00;  // Also the reset value
  localparam logic [7:0]  ROLE_ACTIVE   = 8'h01;
  localparam logic [7:0]  ROLE_STBY1    = 8'h02;
  localparam logic [7:0]  ROLE_STBY2    = 8'h03;
  localparam logic [7:0]  ROLE_STBY3    = 8'h04;

  // Share thresholds, 10 mV per code
  localparam int          SHARE_W       = 12;
  localparam logic [11:0] WAKE_LVL1     = 12'h140; // 3.20 V
  localparam logic [11:0] SLEEP_LVL1    = 12'h090; // 1.44 V
  localparam logic [11:0] WAKE_LVL2     = 12'h1f4; // 5.00 V
  localparam logic [11:0] SLEEP_LVL2    = 12'h12d; // 3.01 V
  localparam logic [11:0] WAKE_LVL3     = 12'h29e; // 6.70 V
  localparam logic [11:0] SLEEP_LVL3    = 12'h1c4; // 4.52 V

  // Synchroniser bit positions and idle levels
  localparam int          SYN_W         = 7;
  localparam int          SY_SCL        = 0;
  localparam int          SY_SDA        = 1;
  localparam int          SY_WAKE       = 2;
  localparam int          SY_ONREQ_N    = 3;
  localparam int          SY_REDEN_N    = 4;
  localparam int          SY_FAULT      = 5;
  localparam int          SY_VLOW       = 6;
  localparam logic [6:0]  SYN_IDLE      = 7'h1f;
  localparam logic [2:0]  DRV_HIST_RST  = 3'h0;

  typedef enum logic [3:0] {
    CS_OFF   = 4'h1,
    CS_ON    = 4'h2,
    CS_SLEEP = 4'h4,
    CS_AWAKE = 4'h8
  } ctrl_state_t;

  typedef enum logic [6:0] {
    BS_IDLE  = 7'h01,
    BS_ADDR  = 7'h02,
    BS_CMD   = 7'h04,
    BS_WDATA = 7'h08,
    BS_WPEC  = 7'h10,
    BS_RDATA = 7'h20,
    BS_RPEC  = 7'h40
  } bus_state_t;

endpackage

// [core/pec_crc8_step.sv]
// Purpose: One byte step of the SMBus packet error code (CRC-8)
// Assumes: Bytes are fed most significant bit first
// Notes:   Purely combinational; the caller holds the running value
`timescale 1ns/100ps
module pec_crc8_step
(
  // Running value and new byte
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data_in,
  // Updated value
  output logic      [7:0] crc_out
);
  import cr_pkg::*;

  // Bitwise shift through the polynomial
  always_comb
  begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ PEC_POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule // pec_crc8_step

// [sim/smb_host_model.sv]
// Purpose: SMBus host and peer supply model for the cold redundancy bench
// Assumes: SDA pulled up; shared line held by a weak pull-down when released
// Notes:   hp sets the host bit phase in clocks; a larger hp gives a slow host
`timescale 1ns/100ps
module smb_host_model
(
  // Clock and device pin drives
  input  wire logic clk,
  input  wire logic dev_sda_oe_n,
  input  wire logic dev_sda_o,
  input  wire logic wf_o,
  input  wire logic wf_oe_n,
  // Resolved wires
  output logic      scl,
  output logic      sda,
  output logic      wf
);
  import cr_pkg::*;
  logic sda_oe_n  = 1'b1;
  logic peer_low  = 1'b0;
  logic peer_high = 1'b1;
  int   hp        = 8;
  initial scl = 1'b1;
  // Open drain; an enabled device puts its data value on SDA
  assign sda = sda_oe_n & (dev_sda_oe_n | dev_sda_o);
  // Low wins; an active peer holds the line high, else the pull-down
  assign wf = ~(peer_low | (~wf_oe_n & ~wf_o)) & (peer_high | ~wf_oe_n);

  // Running CRC-8, poly 07, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction

  task automatic half();
    repeat (hp) @(negedge clk);
  endtask

  // SDA only moves mid-low so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_oe_n = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q,
                      output logic nk);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(rel, nk);
  endtask

  task automatic go_start();
    half();
    sda_oe_n = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_oe_n = 1'b0;
    half();
    scl = 1'b0;
  endtask

  task automatic go_stop();
    half();
    sda_oe_n = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_oe_n = 1'b1;
    half();
  endtask

  // Write byte with PEC; bad flips the code on purpose
  task automatic write_role(input logic [7:0] d, input logic bad, output logic ok);
    logic [7:0] c, q;
    logic       n0, n1, n2, n3;
    c = crc8(crc8(crc8(PEC_INIT, {DEV_ADDR, 1'b0}), CMD_ROLE_CFG), d);
    go_start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, n0);
    xfer(CMD_ROLE_CFG, 1'b1, q, n1);
    xfer(d, 1'b1, q, n2);
    xfer(c ^ {7'h00, bad}, 1'b1, q, n3);
    go_stop();
    ok = ~(n0 | n1 | n2 | n3);
  endtask

  // Read byte with PEC; pe is the code the host expects
  task automatic read_role(output logic [7:0] d, output logic [7:0] p, output logic [7:0] pe);
    logic       n;
    logic [7:0] c;
    go_start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, d, n);
    xfer(CMD_ROLE_CFG, 1'b1, d, n);
    go_start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, d, n);
    xfer(8'hff, 1'b0, d, n);
    xfer(8'hff, 1'b1, p, n);
    go_stop();
    c = crc8(crc8(PEC_INIT, {DEV_ADDR, 1'b0}), CMD_ROLE_CFG);
    pe = crc8(crc8(c, {DEV_ADDR, 1'b1}), d);
  endtask
endmodule // smb_host_model

// [sim/testbench.sv]
// Purpose: Self-checking bench for the cold redundancy controller
// Assumes: Host model drives SMBus; bench inputs change on falling edges
// Notes:   Reference model tracks role as an integer and wake state as a bit
`timescale 1ns/100ps
module testbench;
  import cr_pkg::*;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        onreq_n = 1'b0;
  logic        reden_n = 1'b1;
  logic        ifault  = 1'b0;
  logic        vfault  = 1'b0;
  logic [11:0] share   = 12'h000;
  logic        cpg     = 1'b1;
  logic        scl, sda, sda_o, sda_oe_n, wf, wf_o, wf_oe_n;
  logic        main_on, pg, fans, dummy, ss, stat;
  logic [7:0]  role;
  logic [11:0] wk [3] = '{WAKE_LVL1, WAKE_LVL2, WAKE_LVL3};
  logic [11:0] sl [3] = '{SLEEP_LVL1, SLEEP_LVL2, SLEEP_LVL3};
  int          bad_count, num_checks, cycles, m_role, seed;
  int          exp_q [$];
  logic        m_awake = 1'b0;

  cold_redundancy_controller uut
  (
    .CLK_SYS(clk), .RST_N(rst_n),
    .SMB_SCL_I(scl), .SMB_SDA_I(sda), .SMB_SDA_O(sda_o), .SMB_SDA_OE_N(sda_oe_n),
    .WAKE_FAULT_I(wf), .WAKE_FAULT_O(wf_o), .WAKE_FAULT_OE_N(wf_oe_n),
    .SUPPLY_ON_REQUEST_N(onreq_n), .REDUNDANCY_ENABLE_N(reden_n),
    .INTERNAL_FAULT(ifault), .VOUT_UNDER_FAULT(vfault), .CONV_POWER_GOOD(cpg),
    .SHARE_LEVEL(share), .MAIN_ON(main_on), .POWER_GOOD(pg), .FANS_ON(fans),
    .DUMMY_LOAD_ON(dummy), .SOFT_START_EN(ss), .STATUS_REPORT_EN(stat), .ROLE(role)
  );

  smb_host_model u_host
  (
    .clk(clk), .dev_sda_oe_n(sda_oe_n), .dev_sda_o(sda_o), .wf_o(wf_o), .wf_oe_n(wf_oe_n),
    .scl(scl), .sda(sda), .wf(wf)
  );

  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Hang guard, well above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      results();
    end
  end

  // Expected {main, pgood, fans, dummy, soft start, status, line oe_n, line o}
  function automatic logic [7:0] exp_pins();
    logic [5:0] o;
    logic       sb;
    sb = m_role >= 2 && m_role <= 4 && !onreq_n && reden_n;
    o = onreq_n ? 6'h02 : !sb ? {1'b1, cpg, 4'hf} : m_awake ? {1'b1, cpg, 4'hc} : 6'h10;
    if (ifault | (vfault & o[5]))
      return {o, 2'h0};
    return {o, (m_role == 1 && !sb && !onreq_n) ? 2'h1 : 2'h2};
  endfunction

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Released line value is a don't-care, so it is masked
  task automatic chk_pins();
    repeat (8) @(negedge clk);
    chk_reg({main_on, pg, fans, dummy, ss, stat, wf_oe_n, wf_o & ~wf_oe_n}, exp_pins());
  endtask

  task automatic wr_rd(input logic [7:0] d, input logic bad);
    logic       ok;
    logic [7:0] r, p, pe;
    u_host.write_role(d, bad, ok);
    chk_reg({7'h00, ok}, {7'h00, d <= 8'h04 && !bad});
    if (d <= 8'h04 && !bad)
    begin
      m_role = d;
      m_awake = 1'b0;
    end
    exp_q.push_back(m_role);
    u_host.read_role(r, p, pe);
    chk_reg(r, 8'(exp_q.pop_front()));
    chk_reg(p, pe);
    chk_reg(role, 8'(m_role));
  endtask

  // Hysteresis model, only used while in a standby role
  task automatic set_share(input logic [11:0] v);
    int i;
    share = v;
    i = m_role - 2;
    if (!m_awake && v >= wk[i])
      m_awake = 1'b1;
    else if (m_awake && v < sl[i])
      m_awake = 1'b0;
    chk_pins();
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    seed = 32'h70a6;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_reg(role, ROLE_STANDARD);
    chk_pins();
    $display("test reset done");
    for (int d = 0; d <= 5; d++)
    begin
      wr_rd(8'(d), 1'b0);
      chk_pins();
    end
    wr_rd(ROLE_ACTIVE, 1'b1);
    $display("test roles done");
    for (int r = 2; r <= 4; r++)
    begin
      u_host.hp = (r == 3) ? 20 : 8;
      wr_rd(8'(r), 1'b0);
      set_share(wk[r-2] - 12'h001);
      set_share(wk[r-2]);
      set_share(sl[r-2]);
      set_share(sl[r-2] - 12'h001);
      repeat (4) set_share(12'($unsigned($random(seed))) % wk[r-2]);
      set_share(12'h000);
    end
    $display("test thresholds done");
    wr_rd(ROLE_ACTIVE, 1'b0);
    chk_pins();
    ifault = 1'b1;
    chk_pins();
    ifault = 1'b0;
    wr_rd(ROLE_STANDARD, 1'b0);
    vfault = 1'b1;
    chk_pins();
    vfault = 1'b0;
    chk_pins();
    wr_rd(ROLE_STBY1, 1'b0);
    reden_n = 1'b0;
    chk_pins();
    reden_n = 1'b1;
    onreq_n = 1'b1;
    chk_pins();
    onreq_n = 1'b0;
    cpg = 1'b0;
    chk_pins();
    cpg = 1'b1;
    $display("test faults done");
    wr_rd(ROLE_STBY2, 1'b0);
    u_host.peer_low = 1'b1;
    m_role = 0;
    chk_pins();
    chk_reg(role, ROLE_STANDARD);
    u_host.peer_low = 1'b0;
    chk_pins();
    $display("test wake line done");
    results();
  end
endmodule // testbench
